// file: rtl/rtcc_pkg.sv
// Constants and carrier types for the retry time-out and card control bank.
// Assumes one 10 MHz clock and a config decoder that presents byte accesses.
package rtcc_pkg;

	// Clock period of the config clock
	localparam int CLK_PERIOD_NS = 100;
	// Retry time-out, in config clock cycles (two to the fifteenth)
	localparam int RETRY_TIMEOUT_CYC_DEF = 32768;

	// Register offsets in configuration space
	localparam logic [7:0] OFF_RETRY = 8'h90;
	localparam logic [7:0] OFF_CARD = 8'h91;
	localparam logic [7:0] OFF_DEVCTL = 8'h92;

	// Reset values
	localparam logic [7:0] RETRY_RST = 8'hC0;
	localparam logic [7:0] CARD_RST = 8'h00;
	localparam logic [7:0] DEVCTL_RST = 8'h66;

	// Retry status fields
	localparam int B_PCI_EN = 7;
	localparam int B_CB_EN = 6;
	localparam logic [7:0] RETRY_RSVD_MASK = 8'h15;
	// Timer index order: PCI target, CardBus A, CardBus B
	localparam int NUM_TIMERS = 3;
	localparam int T_PCI = 0;
	localparam int EXP_POS [NUM_TIMERS] = '{1, 3, 5};

	// Card control fields
	localparam int B_RING_EN = 7;
	localparam int B_VIDEO = 6;
	localparam int B_CARD_RSV = 5;
	localparam int B_AUDIO_OFF = 2;
	localparam int B_SPK_EN = 1;
	localparam int B_IRQ_FLAG = 0;

	// Device control fields
	localparam int B_PWR_LOCK = 7;
	localparam int B_LV_FORCE = 6;
	localparam int B_DIAG = 5;
	localparam int B_TEST = 3;
	localparam int B_MODE_HI = 2;
	localparam int B_MODE_LO = 1;
	localparam int B_NAND = 0;

	// Number of sockets and functions
	localparam int NUM_SOCK = 2;

	// Interrupt signalling modes
	typedef enum logic [1:0] {
		RTCC_IRQ_PARALLEL = 2'h0,
		RTCC_IRQ_RSVD = 2'h1,
		RTCC_IRQ_SER_PAR = 2'h2,
		RTCC_IRQ_SERIAL = 2'h3
	} rtcc_irq_mode_e;

	// One configuration byte access
	typedef struct packed {
		logic req;
		logic wr;
		logic func;
		logic [7:0] offset;
		logic [7:0] wdata;
	} rtcc_cfg_req_s;

	// Retry events, one bit per timer in index order
	typedef struct packed {
		logic [NUM_TIMERS-1:0] retried;
		logic [NUM_TIMERS-1:0] returned;
	} rtcc_retry_ev_s;

endpackage

// file: rtl/rtcc_regs.sv
// Retry time-out, card control and device control configuration registers.
// Assumes a config decoder presenting one byte access per cycle on cfg_i,
// retry events from bridge logic on clk_i, and socket pins from outside.
//
// Summary of operation
// - Unanswered retry for 2^15 clocks sets flag.
// - Expired flags sticky, cleared by writing one.
// - Bit 7 enables PCI retry counter, resets one.
// - Bit 6 enables CardBus retry counter, resets one.
// - Bit 5 shows CardBus target B expiry.
// - Bit 3 shows CardBus target A expiry.
// - Bit 1 shows PCI target expiry.
// - Retry status bits 4, 2, 0 read zero.
// - Card bit 7 gates ring output, shared.
// - Card bit 6 tristates video pins only.
// - Card bit 6 aliases per-function socket video enable.
// - Bit 2 clear routes audio; socket 0 wins.
// - Speaker out is XOR, driven when enabled.
// - Per-socket interrupt flag, set by card, W1C.
// - Device control bits 6, 3-0 shared globally.
// - Bits 2-1 pick interrupt mode, default serial.
// - Bit 6 forces low-voltage capability, default one.
module rtcc_regs #(
	parameter int RETRY_TIMEOUT_CYC = rtcc_pkg::RETRY_TIMEOUT_CYC_DEF
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire rtcc_pkg::rtcc_cfg_req_s cfg_i,
	output logic cfg_ack_o,
	output logic [7:0] cfg_rdata_o,
	input wire rtcc_pkg::rtcc_retry_ev_s retry_ev_i,
	input wire logic [1:0] card_func_irq_i,
	input wire logic [1:0] card_speaker_in_i,
	input wire logic [1:0] card_audio_in_i,
	input wire logic ring_in_i,
	output logic ring_indicate_pin_o,
	output logic [1:0] video_pins_tristate_o,
	output logic card_audio_pwm_out_o,
	output logic multipurpose_pin_oe_n_o,
	output logic merged_speaker_out_o,
	output logic merged_speaker_oe_n_o,
	output logic [1:0] card_func_irq_flag_o,
	output logic [1:0] irq_signal_select_o,
	output logic low_volt_capable_force_o
);
	import rtcc_pkg::*;

	// Timer must be able to count at least two cycles
	if (RETRY_TIMEOUT_CYC < 2) begin : g_chk
		$error("rtcc_regs: RETRY_TIMEOUT_CYC must be at least 2");
	end

	// Pins sampled from outside the clock domain
	typedef struct packed {
		logic ring;
		logic [NUM_SOCK-1:0] audio;
		logic [NUM_SOCK-1:0] spk;
		logic [NUM_SOCK-1:0] irq;
	} rtcc_pins_s;

	// Whole state of the bank
	typedef struct packed {
		rtcc_pins_s sync1; // First synchroniser stage
		rtcc_pins_s sync2; // Second stage, safe to read
		logic pci_en; // PCI retry counter enable
		logic cb_en; // CardBus retry counter enable
		logic [NUM_TIMERS-1:0] expired; // Sticky expiry flags
		logic ring_en; // Shared ring output enable
		logic [NUM_SOCK-1:0] video_en; // Per-function video alias
		logic [NUM_SOCK-1:0] card_rsv; // Per-function spare bit
		logic [NUM_SOCK-1:0] audio_off; // One means audio not routed
		logic [NUM_SOCK-1:0] spk_en; // Per-function speaker enable
		logic [NUM_SOCK-1:0] irq_flag; // Per-socket interrupt flag
		logic [NUM_SOCK-1:0] pwr_lock; // Per-function power lock
		logic [NUM_SOCK-1:0] diag; // Per-function diagnostic bit
		logic lv_force; // Shared low-voltage force
		logic test; // Shared test bit
		rtcc_irq_mode_e mode; // Shared interrupt mode
		logic nand_en; // Shared reserved bit 0
		logic ack; // Access answered
		logic [7:0] rdata; // Read data
		logic ring_pin; // Ring output pin
		logic [NUM_SOCK-1:0] zv_hiz; // Video pins released
		logic audio_out; // Audio on the multipurpose pin
		logic audio_oe_n; // Multipurpose pin released when high
		logic spk_out; // Merged speaker output
		logic spk_oe_n; // Speaker pin released when high
	} rtcc_state_s;

	// Reset image built from the documented register defaults
	localparam rtcc_state_s ST_RST = '{
		sync1: '0,
		sync2: '0,
		pci_en: RETRY_RST[B_PCI_EN],
		cb_en: RETRY_RST[B_CB_EN],
		expired: '0,
		ring_en: CARD_RST[B_RING_EN],
		video_en: {NUM_SOCK{CARD_RST[B_VIDEO]}},
		card_rsv: {NUM_SOCK{CARD_RST[B_CARD_RSV]}},
		audio_off: {NUM_SOCK{CARD_RST[B_AUDIO_OFF]}},
		spk_en: {NUM_SOCK{CARD_RST[B_SPK_EN]}},
		irq_flag: {NUM_SOCK{CARD_RST[B_IRQ_FLAG]}},
		pwr_lock: {NUM_SOCK{DEVCTL_RST[B_PWR_LOCK]}},
		diag: {NUM_SOCK{DEVCTL_RST[B_DIAG]}},
		lv_force: DEVCTL_RST[B_LV_FORCE],
		test: DEVCTL_RST[B_TEST],
		mode: rtcc_irq_mode_e'(DEVCTL_RST[B_MODE_HI:B_MODE_LO]),
		nand_en: DEVCTL_RST[B_NAND],
		ack: 1'b0,
		rdata: '0,
		ring_pin: 1'b0,
		zv_hiz: '0,
		audio_out: 1'b0,
		audio_oe_n: 1'b1,
		spk_out: 1'b0,
		spk_oe_n: 1'b1
	};

	rtcc_state_s st_r;
	rtcc_state_s st_nxt;
	logic [NUM_TIMERS-1:0] expire_pulse; // From the timers
	logic [NUM_TIMERS-1:0] timer_en; // Enable per timer

	// Offset hit, used for both read and write decoding
	function automatic logic cfg_hit(input rtcc_cfg_req_s c,
		input logic [7:0] off);
		cfg_hit = c.req && (c.offset == off);
	endfunction

	// PCI timer follows bit 7, both CardBus timers follow bit 6
	always_comb begin
		timer_en = {NUM_TIMERS{st_r.cb_en}};
		timer_en[T_PCI] = st_r.pci_en;
	end

	// One counter per retried target
	for (genvar k = 0; k < NUM_TIMERS; k++) begin : g_tmr
		rtcc_retry_timer #(
			.LIMIT(RETRY_TIMEOUT_CYC)
		) u_tmr (
			.clk_i(clk_i),
			.sys_rst_i(sys_rst_i),
			.ce_i(ce_i),
			.enable_i(timer_en[k]),
			.retried_i(retry_ev_i.retried[k]),
			.returned_i(retry_ev_i.returned[k]),
			.expired_o(expire_pulse[k])
		);
	end

	// Next-state of the whole bank
	always_comb begin
		logic f;
		logic [7:0] w;
		logic wr_retry;
		logic wr_card;
		logic wr_dev;
		st_nxt = st_r;
		f = cfg_i.func;
		w = cfg_i.wdata;
		wr_retry = cfg_hit(cfg_i, OFF_RETRY) && cfg_i.wr;
		wr_card = cfg_hit(cfg_i, OFF_CARD) && cfg_i.wr;
		wr_dev = cfg_hit(cfg_i, OFF_DEVCTL) && cfg_i.wr;

		// Two-stage synchroniser for every pin input
		st_nxt.sync1 = '{ring: ring_in_i, audio: card_audio_in_i,
			spk: card_speaker_in_i, irq: card_func_irq_i};
		st_nxt.sync2 = st_r.sync1;

		// Retry status: both functions decode it, one copy serves both
		if (wr_retry) begin
			st_nxt.pci_en = w[B_PCI_EN];
			st_nxt.cb_en = w[B_CB_EN];
		end
		for (int k = 0; k < NUM_TIMERS; k++) begin
			// Expiry set beats a same-cycle clear
			if (wr_retry && w[EXP_POS[k]]) begin
				st_nxt.expired[k] = 1'b0;
			end
			if (expire_pulse[k]) begin
				st_nxt.expired[k] = 1'b1;
			end
		end

		// Card control: bit 7 shared, the rest follow the function
		if (wr_card) begin
			st_nxt.ring_en = w[B_RING_EN];
			st_nxt.video_en[f] = w[B_VIDEO];
			st_nxt.card_rsv[f] = w[B_CARD_RSV];
			st_nxt.audio_off[f] = w[B_AUDIO_OFF];
			st_nxt.spk_en[f] = w[B_SPK_EN];
			if (w[B_IRQ_FLAG]) begin
				st_nxt.irq_flag[f] = 1'b0;
			end
		end
		// Card interrupt sets its own socket's flag, set wins
		st_nxt.irq_flag = st_nxt.irq_flag | st_r.sync2.irq;

		// Device control: bits 6 and 3-0 are one shared copy
		if (wr_dev) begin
			st_nxt.pwr_lock[f] = w[B_PWR_LOCK];
			st_nxt.diag[f] = w[B_DIAG];
			st_nxt.lv_force = w[B_LV_FORCE];
			st_nxt.test = w[B_TEST];
			// Reserved mode code is kept as written
			st_nxt.mode =
				rtcc_irq_mode_e'(w[B_MODE_HI:B_MODE_LO]);
			st_nxt.nand_en = w[B_NAND];
		end

		// Every access is answered one cycle later
		st_nxt.ack = cfg_i.req;
		st_nxt.rdata = '0;
		if (cfg_hit(cfg_i, OFF_RETRY) && !cfg_i.wr) begin
			// Reserved bits stay zero
			st_nxt.rdata[B_PCI_EN] = st_r.pci_en;
			st_nxt.rdata[B_CB_EN] = st_r.cb_en;
			for (int k = 0; k < NUM_TIMERS; k++) begin
				st_nxt.rdata[EXP_POS[k]] = st_r.expired[k];
			end
		end else if (cfg_hit(cfg_i, OFF_CARD) && !cfg_i.wr) begin
			st_nxt.rdata[B_RING_EN] = st_r.ring_en;
			st_nxt.rdata[B_VIDEO] = st_r.video_en[f];
			st_nxt.rdata[B_CARD_RSV] = st_r.card_rsv[f];
			st_nxt.rdata[B_AUDIO_OFF] = st_r.audio_off[f];
			st_nxt.rdata[B_SPK_EN] = st_r.spk_en[f];
			st_nxt.rdata[B_IRQ_FLAG] = st_r.irq_flag[f];
		end else if (cfg_hit(cfg_i, OFF_DEVCTL) && !cfg_i.wr) begin
			st_nxt.rdata[B_PWR_LOCK] = st_r.pwr_lock[f];
			st_nxt.rdata[B_LV_FORCE] = st_r.lv_force;
			st_nxt.rdata[B_DIAG] = st_r.diag[f];
			st_nxt.rdata[B_TEST] = st_r.test;
			st_nxt.rdata[B_MODE_HI:B_MODE_LO] = st_r.mode;
			st_nxt.rdata[B_NAND] = st_r.nand_en;
		end

		// Pin outputs, all registered
		st_nxt.ring_pin = st_r.ring_en & st_r.sync2.ring;
		// High bit only releases the pins, it never drives video
		st_nxt.zv_hiz = st_r.video_en;
		// Socket 0 audio takes the pin when both ask for it
		if (!st_r.audio_off[0]) begin
			st_nxt.audio_out = st_r.sync2.audio[0];
			st_nxt.audio_oe_n = 1'b0;
		end else if (!st_r.audio_off[1]) begin
			st_nxt.audio_out = st_r.sync2.audio[1];
			st_nxt.audio_oe_n = 1'b0;
		end else begin
			st_nxt.audio_out = 1'b0;
			st_nxt.audio_oe_n = 1'b1;
		end
		// Either function's enable drives the merged speaker
		st_nxt.spk_out = ^st_r.sync2.spk;
		st_nxt.spk_oe_n = ~|st_r.spk_en;
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= ST_RST;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from state
	assign cfg_ack_o = st_r.ack;
	assign cfg_rdata_o = st_r.rdata;
	assign ring_indicate_pin_o = st_r.ring_pin;
	assign video_pins_tristate_o = st_r.zv_hiz;
	assign card_audio_pwm_out_o = st_r.audio_out;
	assign multipurpose_pin_oe_n_o = st_r.audio_oe_n;
	assign merged_speaker_out_o = st_r.spk_out;
	assign merged_speaker_oe_n_o = st_r.spk_oe_n;
	assign card_func_irq_flag_o = st_r.irq_flag;
	assign irq_signal_select_o = st_r.mode;
	assign low_volt_capable_force_o = st_r.lv_force;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// Write of the retry status register, any data pattern
	sequence s_retry_wr;
		ce_i && cfg_i.req && cfg_i.wr && cfg_i.offset == OFF_RETRY;
	endsequence

	// Retry status read request
	sequence s_retry_rd;
		ce_i && cfg_i.req && !cfg_i.wr && cfg_i.offset == OFF_RETRY;
	endsequence

	a_expire_sets: assert property (
		ce_i && expire_pulse[T_PCI] |=> st_r.expired[T_PCI])
		else $error("expiry pulse did not set the flag");

	a_flag_sticky: assert property (
		ce_i && st_r.expired[2] && !(cfg_i.req && cfg_i.wr &&
		cfg_i.offset == OFF_RETRY && cfg_i.wdata[EXP_POS[2]])
		|=> st_r.expired[2])
		else $error("expired flag lost without a write of one");

	a_flag_clear: assert property (
		s_retry_wr ##0 (cfg_i.wdata[EXP_POS[1]] && !expire_pulse[1])
		|=> !st_r.expired[1])
		else $error("write of one did not clear the flag");

	a_rsvd_zero: assert property (
		s_retry_rd |=> cfg_ack_o && (cfg_rdata_o & RETRY_RSVD_MASK) == '0)
		else $error("reserved retry status bits read nonzero");

	a_rd_flags: assert property (
		s_retry_rd |=> cfg_rdata_o[EXP_POS[T_PCI]] ==
		$past(st_r.expired[T_PCI]))
		else $error("PCI expiry bit read wrong");

	a_ring_gate: assert property (
		ce_i && !st_r.ring_en |=> !ring_indicate_pin_o)
		else $error("ring pin active while disabled");

	a_speaker_mix: assert property (
		ce_i |=> merged_speaker_out_o == ^$past(st_r.sync2.spk) &&
		merged_speaker_oe_n_o == !(|$past(st_r.spk_en)))
		else $error("speaker merge or enable wrong");

	a_audio_prio: assert property (
		ce_i && !st_r.audio_off[0] |=> !multipurpose_pin_oe_n_o &&
		card_audio_pwm_out_o == $past(st_r.sync2.audio[0]))
		else $error("socket 0 audio not routed");

	a_video_hiz: assert property (
		ce_i |=> video_pins_tristate_o == $past(st_r.video_en))
		else $error("video tristate does not follow alias bit");

	a_irq_set: assert property (
		ce_i && st_r.sync2.irq[1] |=> card_func_irq_flag_o[1])
		else $error("card interrupt did not set its flag");

	a_timer_en_off: assert property (
		ce_i && !st_r.pci_en |=> (!expire_pulse[T_PCI])[*2])
		else $error("disabled PCI timer expired");

endmodule

// file: rtl/rtcc_retry_timer.sv
// One retry time-out counter with a single-cycle expiry pulse.
// Assumes retry and return strobes are synchronous to clk_i.
module rtcc_retry_timer #(
	parameter int LIMIT = rtcc_pkg::RETRY_TIMEOUT_CYC_DEF
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic enable_i,
	input wire logic retried_i,
	input wire logic returned_i,
	output logic expired_o
);
	import rtcc_pkg::*;

	localparam int CW = $clog2(LIMIT);
	localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

	// Counter needs at least two states to mean anything
	if (LIMIT < 2) begin : g_chk
		$error("rtcc_retry_timer: LIMIT must be at least 2");
	end

	typedef struct packed {
		logic pending; // A retried master has not yet come back
		logic [CW-1:0] cnt; // Cycles waited so far
		logic expired; // One-cycle expiry pulse
	} rtcc_tmr_s;

	rtcc_tmr_s st_r;
	rtcc_tmr_s st_nxt;

	// Next-state: return wins over a new retry in the same cycle
	always_comb begin
		st_nxt = st_r;
		st_nxt.expired = 1'b0;
		if (!enable_i) begin
			// Disabled timer sits at zero
			st_nxt.pending = 1'b0;
			st_nxt.cnt = '0;
		end else if (returned_i) begin
			// Master came back, restart
			st_nxt.pending = 1'b0;
			st_nxt.cnt = '0;
		end else if (retried_i) begin
			st_nxt.pending = 1'b1;
			st_nxt.cnt = '0;
		end else if (st_r.pending) begin
			if (st_r.cnt == LAST) begin
				// Waited the full time-out
				st_nxt.expired = 1'b1;
				st_nxt.pending = 1'b0;
				st_nxt.cnt = '0;
			end else begin
				st_nxt.cnt = st_r.cnt + 1'b1;
			end
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= '0;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	assign expired_o = st_r.expired;

	a_timer_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && !enable_i |=> st_r.cnt == '0 && !st_r.pending)
		else $error("timer not held at zero while disabled");

	a_timer_expire: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ce_i && enable_i && !returned_i && !retried_i && st_r.pending &&
		st_r.cnt == LAST |=> expired_o && !st_r.pending)
		else $error("timer did not expire at the limit");

	// Only the rising pulse is checked: a low clock enable may stretch it
	a_timer_early: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(expired_o) |-> $past(st_r.cnt) == LAST)
		else $error("timer expired before the limit");

endmodule

// file: tb/rtcc_master_model.sv
// Model of the bus masters that the bridge retries, one per retry timer.
// Assumes one caller at a time and that calls start just after a clk_i edge.
module rtcc_master_model (
	input wire logic clk_i,
	output rtcc_pkg::rtcc_retry_ev_s retry_ev_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import rtcc_pkg::*;

	// Idle masters: nothing retried, nothing returning
	initial begin
		retry_ev_o = '0;
	end

	// Master k is retried, then comes back after dly cycles (0 means never)
	task automatic issue(input int k, input int dly);
		@(posedge clk_i);
		#10 retry_ev_o.retried[k] = 1'b1;
		@(posedge clk_i);
		#10 retry_ev_o.retried[k] = 1'b0;
		// A late master would be indistinguishable, so only early returns
		if (dly > 0) begin
			repeat (dly) @(posedge clk_i);
			#10 retry_ev_o.returned[k] = 1'b1;
			@(posedge clk_i);
			#10 retry_ev_o.returned[k] = 1'b0;
		end
	endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the retry, card and device control bank.
// Assumes a shortened retry limit; ce_i is dropped once to test freezing.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
	$display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
	num_errors++; end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rtcc_pkg::*;

	localparam int LIM = 16; // Short retry limit keeps the run brief
	localparam int MAX_CYC = 4000; // Hang ceiling
	logic clk_i;
	logic sys_rst_i;
	logic ce; // Clock enable to the bank
	rtcc_cfg_req_s cfg;
	rtcc_retry_ev_s retry_ev;
	logic [1:0] irq_in, spk_in, aud_in;
	logic ring_in;
	logic ack, ring_pin, aud_out, aud_oe_n, spk_out, spk_oe_n, lv_force;
	logic [7:0] rdata, rd_q;
	logic [1:0] vid_z, irq_flag, irq_sel;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	rtcc_regs #(.RETRY_TIMEOUT_CYC(LIM)) rtcc_regs_inst (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce),
		.cfg_i(cfg),
		.cfg_ack_o(ack),
		.cfg_rdata_o(rdata),
		.retry_ev_i(retry_ev),
		.card_func_irq_i(irq_in),
		.card_speaker_in_i(spk_in),
		.card_audio_in_i(aud_in),
		.ring_in_i(ring_in),
		.ring_indicate_pin_o(ring_pin),
		.video_pins_tristate_o(vid_z),
		.card_audio_pwm_out_o(aud_out),
		.multipurpose_pin_oe_n_o(aud_oe_n),
		.merged_speaker_out_o(spk_out),
		.merged_speaker_oe_n_o(spk_oe_n),
		.card_func_irq_flag_o(irq_flag),
		.irq_signal_select_o(irq_sel),
		.low_volt_capable_force_o(lv_force)
	);

	rtcc_master_model rtcc_master_model_inst (
		.clk_i(clk_i),
		.retry_ev_o(retry_ev)
	);

	// Free-running 10 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// Verdict and end of run, single exit point
	task automatic end_sim();
		if (num_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hang guard: a stuck run counts as a mismatch
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == MAX_CYC) begin
			num_errors++;
			end_sim();
		end
	end

	// One byte access; ack is due on the edge that takes the request
	task automatic acc(input logic w, input logic f, input logic [7:0] off,
		input logic [7:0] wd);
		cfg = '{req: 1'b1, wr: w, func: f, offset: off, wdata: wd};
		@(posedge clk_i);
		#10 cfg.req = 1'b0;
		`CHK(ack, 1'b1)
		rd_q = rdata;
		@(posedge clk_i);
		#10;
	endtask

	// Register write
	task automatic wr(input logic f, input logic [7:0] off, input logic [7:0] d);
		acc(1'b1, f, off, d);
	endtask

	// Register read against an expected byte
	task automatic rd(input logic f, input logic [7:0] off, input logic [7:0] e);
		acc(1'b0, f, off, 8'h00);
		`CHK(rd_q, e)
	endtask

	// Let n edges pass; pins lag inputs by three edges
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_i);
		#10;
	endtask

	// Main sequence
	initial begin
		logic [7:0] m;
		ce = 1'b1;
		cfg = '0;
		irq_in = 2'h0;
		spk_in = 2'h0;
		aud_in = 2'h0;
		ring_in = 1'b0;
		sys_rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#10 sys_rst_i = 1'b0;
		// Reset values and unmapped space
		rd(0, OFF_RETRY, 8'hC0);
		rd(0, OFF_CARD, 8'h00);
		rd(0, OFF_DEVCTL, 8'h66);
		rd(0, 8'h95, 8'h00);
		`CHK(irq_sel, 2'h3)
		`CHK(lv_force, 1'b1)
		// Ones to flags and reserved bits change nothing
		wr(0, OFF_RETRY, 8'hFF);
		rd(0, OFF_RETRY, 8'hC0);
		// Each master left unanswered: silent before limit, flag after
		for (int k = 0; k < NUM_TIMERS; k++) begin
			m = 8'h01 << EXP_POS[k];
			rtcc_master_model_inst.issue(k, 0);
			// Last read before the flag lands, then the first after
			wait_cyc(LIM);
			rd(0, OFF_RETRY, 8'hC0);
			rd(0, OFF_RETRY, 8'hC0 | m);
			wr(0, OFF_RETRY, 8'hC0);
			rd(0, OFF_RETRY, 8'hC0 | m);
			wr(0, OFF_RETRY, 8'hC0 | m);
			rd(0, OFF_RETRY, 8'hC0);
		end
		// Clock enable low freezes the count, so expiry slips by the gap
		rtcc_master_model_inst.issue(0, 0);
		wait_cyc(2);
		ce = 1'b0;
		wait_cyc(20);
		ce = 1'b1;
		rd(0, OFF_RETRY, 8'hC0);
		wait_cyc(LIM - 4);
		rd(0, OFF_RETRY, 8'hC0);
		rd(0, OFF_RETRY, 8'hC2);
		wr(0, OFF_RETRY, 8'hC2);
		// A master returning just before the limit leaves no flag
		rtcc_master_model_inst.issue(0, LIM - 4);
		wait_cyc(LIM + 4);
		rd(0, OFF_RETRY, 8'hC0);
		// Both counters disabled, then PCI only
		wr(0, OFF_RETRY, 8'h00);
		rtcc_master_model_inst.issue(0, 0);
		rtcc_master_model_inst.issue(1, 0);
		wait_cyc(LIM + 6);
		rd(0, OFF_RETRY, 8'h00);
		wr(0, OFF_RETRY, 8'h80);
		rtcc_master_model_inst.issue(2, 0);
		rtcc_master_model_inst.issue(0, 0);
		wait_cyc(LIM + 6);
		rd(0, OFF_RETRY, 8'h82);
		wr(0, OFF_RETRY, 8'hC2);
		rd(0, OFF_RETRY, 8'hC0);
		// Ring output gate, shared across functions
		ring_in = 1'b1;
		wr(0, OFF_CARD, 8'h80);
		wait_cyc(4);
		`CHK(ring_pin, 1'b1)
		rd(1, OFF_CARD, 8'h80);
		// Video tristate alias per function
		wr(0, OFF_CARD, 8'h40);
		wait_cyc(2);
		`CHK(ring_pin, 1'b0)
		`CHK(vid_z, 2'h1)
		rd(1, OFF_CARD, 8'h00);
		wr(1, OFF_CARD, 8'h40);
		wait_cyc(2);
		`CHK(vid_z, 2'h3)
		// Speaker merge driven by function 1's enable
		wr(0, OFF_CARD, 8'h00);
		spk_in = 2'h1;
		wr(1, OFF_CARD, 8'h02);
		wait_cyc(4);
		`CHK(spk_oe_n, 1'b0)
		`CHK(spk_out, 1'b1)
		spk_in = 2'h3;
		wait_cyc(4);
		`CHK(spk_out, 1'b0)
		wr(1, OFF_CARD, 8'h00);
		wait_cyc(2);
		`CHK(spk_oe_n, 1'b1)
		// Audio routing: socket 0 wins, then socket 1, then none
		aud_in = 2'h2;
		wait_cyc(4);
		`CHK(aud_oe_n, 1'b0)
		`CHK(aud_out, 1'b0)
		wr(0, OFF_CARD, 8'h04);
		wait_cyc(4);
		`CHK(aud_out, 1'b1)
		wr(1, OFF_CARD, 8'h04);
		wait_cyc(2);
		`CHK(aud_oe_n, 1'b1)
		wr(0, OFF_CARD, 8'h00);
		wr(1, OFF_CARD, 8'h00);
		// Functional interrupt on socket 1 only, sticky until cleared
		irq_in = 2'h2;
		wait_cyc(4);
		irq_in = 2'h0;
		wait_cyc(4);
		`CHK(irq_flag, 2'h2)
		rd(1, OFF_CARD, 8'h01);
		rd(0, OFF_CARD, 8'h00);
		wr(1, OFF_CARD, 8'h01);
		wait_cyc(2);
		`CHK(irq_flag, 2'h0)
		// Every interrupt mode, read back through both functions
		for (int md = 0; md < 4; md++) begin
			m = 8'h60 | (8'(md) << 1);
			wr(0, OFF_DEVCTL, m);
			rd(0, OFF_DEVCTL, m);
			rd(1, OFF_DEVCTL, m);
			wait_cyc(2);
			`CHK(irq_sel, 2'(md))
		end
		// Shared bits written from function 1 reach function 0
		wr(1, OFF_DEVCTL, 8'h02);
		rd(0, OFF_DEVCTL, 8'h22);
		wait_cyc(2);
		`CHK(lv_force, 1'b0)
		`CHK(irq_sel, 2'h1)
		// Mid-run reset brings the shared defaults back
		sys_rst_i = 1'b1;
		wait_cyc(2);
		sys_rst_i = 1'b0;
		rd(1, OFF_DEVCTL, 8'h66);
		`CHK(lv_force, 1'b1)
		`CHK(irq_sel, 2'h3)
		end_sim();
	end
endmodule
